// ==== hdl/etdt_defines.svh ====
`ifndef ETDT_DEFINES_SVH
`define ETDT_DEFINES_SVH
// ==========================================================
// Register indices (byte address is four times the index)
`define ETDT_IDX_AUX_STATUS  6'h05
`define ETDT_IDX_CMD_CTRL    6'h09
`define ETDT_IDX_COUNT_NOW   6'h0C
`define ETDT_IDX_TICK_DIV    6'h2A
`define ETDT_IDX_TRIG_EN     6'h2B
`define ETDT_IDX_RELOAD      6'h2C
`define ETDT_IDX_FLAGS       6'h30
`define ETDT_IDX_SLOT_LO     6'h31
`define ETDT_IDX_AUX_SEL     6'h32
// ==========================================================
// Field positions
`define ETDT_BIT_ACTIVE      7
`define ETDT_BIT_GO          1
`define ETDT_BIT_HALT        2
`define ETDT_BIT_AUTO        5
`define ETDT_BIT_TX_FIRST    0
`define ETDT_BIT_TX_LAST     1
`define ETDT_BIT_RX_FIRST    2
`define ETDT_BIT_RX_LAST     3
`define ETDT_BIT_TIMEOUT     0
`define ETDT_BIT_SLOT_MSB    0
// ==========================================================
// Reset values and limits
`define ETDT_RST_BYTE        8'h00
`define ETDT_DIV_MAX         5'd21
// ==========================================================
// Chip clock rate and bus clock rate in kHz
`define ETDT_CHIP_KHZ        18'd13560
`define ETDT_PCLK_KHZ        18'd200000
`endif

// ==== hdl/etdt_pkg.sv ====
package etdt_pkg;
	// One-hot timer states
	typedef enum logic [1:0] {
		ETDT_IDLE = 2'b01,
		ETDT_RUN  = 2'b10
	} etdt_state_t;
	// Link events, one-cycle pulses
	typedef struct packed {
		logic tx_first_bit_evt;
		logic tx_last_bit_evt;
		logic rx_first_bit_evt;
		logic rx_last_bit_evt;
	} etdt_evt_t;
	// Timer configuration snapshot
	typedef struct packed {
		logic       auto_reload_en;
		logic [4:0] tick_divider;
	} etdt_cfg_t;
endpackage

// ==== hdl/etdt_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "etdt_defines.svh"
module etdt_prescaler (
	input  wire logic       pclk,     // Bus clock
	input  wire logic       presetn,  // Async reset, low
	input  wire logic       ce,       // Clock enable
	input  wire logic       restart,  // Realign divider
	input  wire logic [4:0] div,      // Power-of-two exponent
	output logic            tick      // One-cycle tick
);
	logic [17:0] acc_q, acc_d;
	logic [20:0] cnt_q, cnt_d;
	logic        tick_q, tick_d;
	logic        chip;
	logic [20:0] mask;
	logic [18:0] sum;

	// ==========================================================
	// Phase accumulator makes an exact 13.56 MHz average strobe
	always_comb begin
		sum    = {1'b0, acc_q} + {1'b0, `ETDT_CHIP_KHZ};
		chip   = (sum >= {1'b0, `ETDT_PCLK_KHZ});
		mask   = 21'(((22'h1) << div) - 22'h1);
		acc_d  = acc_q;
		cnt_d  = cnt_q;
		tick_d = tick_q;
		if (ce) begin
			acc_d  = chip ? 18'(sum - {1'b0, `ETDT_PCLK_KHZ}) : sum[17:0];
			tick_d = 1'b0;
			// Phase cleared too, else the first tick comes up to a strobe early
			if (restart) begin
				acc_d = 18'h0;
				cnt_d = 21'h0;
			end else if (chip) begin
				if (cnt_q == mask) begin
					cnt_d  = 21'h0;
					tick_d = 1'b1;
				end else begin
					cnt_d = cnt_q + 21'h1;
				end
			end
		end
	end

	// Registers only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q  <= 18'h0;
			cnt_q  <= 21'h0;
			tick_q <= 1'b0;
		end else begin
			acc_q  <= acc_d;
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;
endmodule
`default_nettype wire

// ==== hdl/etdt_top.sv ====
// Contract
// [RQ1] Nonzero count decrements each divided tick
// [RQ2] Tick period is two-power divider over chip
// [RQ3] Start on tx first, tx last, or go
// [RQ4] Every start loads reload value, retriggers
// [RQ5] Stop on rx events, zero, or halt
// [RQ6] Auto reload skips zero, reloads after one
// [RQ7] Config writes only matter at next start
// [RQ8] Software halt never raises timeout flag
// [RQ9] Active flag follows start and stop
// [RQ10] Current count always readable
// [RQ11] Early stop silent, reaching zero flags
// [RQ12] Timeout never touches tx or rx
// [RQ13] Slot counter after command, sends queued data
// [RQ14] Slot interval is period encoder ticks
// [RQ15] New slot period applies at restart
// [RQ16] Slot period ninth bit in aux select
// [RQ17] Software clears check append before quit
// [RQ18] Auto reload gives periodic timeout flags
// [RQ19] Flag on one-to-zero or one-to-reload
// [RQ20] Go and halt are self-clearing pulses
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "etdt_defines.svh"
module etdt_top (
	input  wire logic              pclk,             // 200 MHz clock
	input  wire logic              presetn,          // Async reset
	input  wire logic              ce,               // Freeze when low
	input  wire logic              psel,             // APB select
	input  wire logic              penable,          // APB enable
	input  wire logic              pwrite,           // APB direction
	input  wire logic [7:0]        paddr,            // APB address
	input  wire logic [31:0]       pwdata,           // APB write data
	output logic      [31:0]       prdata,           // APB read data
	output logic                   pready,           // APB ready
	output logic                   pslverr,          // APB error
	input  wire etdt_pkg::etdt_evt_t evt,            // Link events
	input  wire logic              cmd_done,         // Command ended
	input  wire logic              fifo_has_data,    // Queue not empty
	input  wire logic              encoder_tick,     // Encoder rate
	output logic                   timeout_irq_flag, // Timeout flag
	output logic                   count_active,     // Timer running
	output logic                   slot_send         // Send request
);
	import etdt_pkg::*;

	// ==========================================================
	// Register file state
	logic [3:0]  trig_q, trig_d;
	etdt_cfg_t   cfg_q, cfg_d;
	logic [7:0]  reload_q, reload_d;
	logic [7:0]  slot_lo_q, slot_lo_d;
	logic        slot_msb_q, slot_msb_d;
	logic        go_q, go_d;
	logic        halt_q, halt_d;
	logic [31:0] prdata_q, prdata_d;
	logic        pready_q, pready_d;
	logic        pslverr_q, pslverr_d;
	logic        irq_clr;
	logic [5:0]  idx;
	logic        setup;
	logic        wr_en;

	// Timer state
	etdt_state_t state_q, state_d;
	logic [7:0]  count_q, count_d;
	logic [7:0]  run_rel_q, run_rel_d;
	etdt_cfg_t   run_cfg_q, run_cfg_d;
	logic        irq_q, irq_d;
	logic        irq_set;
	logic        restart;
	logic        tick;
	logic        running;
	logic        start_any;
	logic        stop_any;

	// Slot state
	logic        slot_on_q, slot_on_d;
	logic [8:0]  slot_cnt_q, slot_cnt_d;
	logic        send_q, send_d;
	logic [8:0]  period;

	assign idx     = paddr[7:2];
	assign setup   = psel & ~penable;
	assign wr_en   = psel & penable & pready_q & pwrite;
	assign running = (state_q == ETDT_RUN);
	assign period  = {slot_msb_q, slot_lo_q}; // see [RQ16]

	// Decode used only for the error answer; the read mux decodes the index on its own
	function automatic logic idx_mapped(input logic [5:0] i);
		if (i == `ETDT_IDX_AUX_STATUS) begin
			return 1'b1;
		end else if (i == `ETDT_IDX_CMD_CTRL) begin
			return 1'b1;
		end else if (i == `ETDT_IDX_COUNT_NOW) begin
			return 1'b1;
		end else if (i == `ETDT_IDX_TICK_DIV) begin
			return 1'b1;
		end else if (i == `ETDT_IDX_TRIG_EN) begin
			return 1'b1;
		end else if (i == `ETDT_IDX_RELOAD) begin
			return 1'b1;
		end else if (i == `ETDT_IDX_FLAGS) begin
			return 1'b1;
		end else if (i == `ETDT_IDX_SLOT_LO) begin
			return 1'b1;
		end else if (i == `ETDT_IDX_AUX_SEL) begin
			return 1'b1;
		end else begin
			return 1'b0;
		end
	endfunction

	// ==========================================================
	// APB slave: no wait state; read data come from a flop loaded in the setup cycle
	always_comb begin
		trig_d     = trig_q;
		cfg_d      = cfg_q;
		reload_d   = reload_q;
		slot_lo_d  = slot_lo_q;
		slot_msb_d = slot_msb_q;
		go_d       = go_q;
		halt_d     = halt_q;
		prdata_d   = prdata_q;
		pready_d   = pready_q;
		pslverr_d  = pslverr_q;
		irq_clr    = 1'b0;
		if (ce) begin
			go_d      = 1'b0; // see [RQ20]
			halt_d    = 1'b0; // see [RQ20]
			pready_d  = setup;
			pslverr_d = setup & ~idx_mapped(idx);
			if (setup && !pwrite) begin
				prdata_d = 32'h0;
				if (idx == `ETDT_IDX_AUX_STATUS) begin
					prdata_d[`ETDT_BIT_ACTIVE] = running; // see [RQ9]
				end else if (idx == `ETDT_IDX_COUNT_NOW) begin
					prdata_d[7:0] = count_q; // see [RQ10]
				end else if (idx == `ETDT_IDX_TICK_DIV) begin
					prdata_d[5:0] = cfg_q;
				end else if (idx == `ETDT_IDX_TRIG_EN) begin
					prdata_d[3:0] = trig_q;
				end else if (idx == `ETDT_IDX_RELOAD) begin
					prdata_d[7:0] = reload_q;
				end else if (idx == `ETDT_IDX_FLAGS) begin
					prdata_d[`ETDT_BIT_TIMEOUT] = irq_q;
				end else if (idx == `ETDT_IDX_SLOT_LO) begin
					prdata_d[7:0] = slot_lo_q;
				end else if (idx == `ETDT_IDX_AUX_SEL) begin
					prdata_d[`ETDT_BIT_SLOT_MSB] = slot_msb_q;
				end
			end
			// Writes land only in the access cycle with pready high
			if (wr_en) begin
				if (idx == `ETDT_IDX_CMD_CTRL) begin
					go_d   = pwdata[`ETDT_BIT_GO];
					halt_d = pwdata[`ETDT_BIT_HALT];
				end else if (idx == `ETDT_IDX_TICK_DIV) begin
					cfg_d = pwdata[5:0]; // see [RQ7]
				end else if (idx == `ETDT_IDX_TRIG_EN) begin
					trig_d = pwdata[3:0];
				end else if (idx == `ETDT_IDX_RELOAD) begin
					reload_d = pwdata[7:0]; // see [RQ7]
				end else if (idx == `ETDT_IDX_FLAGS) begin
					irq_clr = pwdata[`ETDT_BIT_TIMEOUT];
				end else if (idx == `ETDT_IDX_SLOT_LO) begin
					slot_lo_d = pwdata[7:0]; // see [RQ15]
				end else if (idx == `ETDT_IDX_AUX_SEL) begin
					slot_msb_d = pwdata[`ETDT_BIT_SLOT_MSB];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_q     <= 4'h0;
			cfg_q      <= 6'h00;
			reload_q   <= `ETDT_RST_BYTE;
			slot_lo_q  <= `ETDT_RST_BYTE;
			slot_msb_q <= 1'b0;
			go_q       <= 1'b0;
			halt_q     <= 1'b0;
			prdata_q   <= 32'h0;
			pready_q   <= 1'b0;
			pslverr_q  <= 1'b0;
		end else begin
			trig_q     <= trig_d;
			cfg_q      <= cfg_d;
			reload_q   <= reload_d;
			slot_lo_q  <= slot_lo_d;
			slot_msb_q <= slot_msb_d;
			go_q       <= go_d;
			halt_q     <= halt_d;
			prdata_q   <= prdata_d;
			pready_q   <= pready_d;
			pslverr_q  <= pslverr_d;
		end
	end

	// ==========================================================
	// Tick source; restarting it on a start gives a full first tick
	etdt_prescaler u_presc (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.restart (restart),
		.div     (run_cfg_q.tick_divider), // see [RQ2]
		.tick    (tick)
	);

	// Start and stop sources; link events qualified by the enable bits, go and halt always act
	assign start_any = go_q
		| (evt.tx_first_bit_evt & trig_q[`ETDT_BIT_TX_FIRST])
		| (evt.tx_last_bit_evt & trig_q[`ETDT_BIT_TX_LAST]); // see [RQ3]
	assign stop_any = halt_q
		| (evt.rx_first_bit_evt & trig_q[`ETDT_BIT_RX_FIRST])
		| (evt.rx_last_bit_evt & trig_q[`ETDT_BIT_RX_LAST]); // see [RQ5]

	// ==========================================================
	// Down-counter; while running, stops win over starts in the same cycle
	always_comb begin
		state_d   = state_q;
		count_d   = count_q;
		run_rel_d = run_rel_q;
		run_cfg_d = run_cfg_q;
		irq_set   = 1'b0;
		restart   = 1'b0;
		if (ce) begin
			case (state_q)
				ETDT_RUN: begin
					if (stop_any) begin
						state_d = ETDT_IDLE; // see [RQ5] [RQ8] [RQ11]
					end else if (start_any) begin
						count_d   = reload_q; // see [RQ4]
						run_rel_d = reload_q;
						run_cfg_d = cfg_q;
						restart   = 1'b1;
					end else if (tick) begin
						if (count_q == 8'h00) begin
							state_d = ETDT_IDLE;
						end else if (count_q == 8'h01) begin
							irq_set = 1'b1; // see [RQ19] [RQ11]
							if (run_cfg_q.auto_reload_en) begin
								count_d = run_rel_q; // see [RQ6] [RQ18]
							end else begin
								count_d = 8'h00;
								state_d = ETDT_IDLE; // see [RQ5]
							end
						end else begin
							count_d = count_q - 8'h01; // see [RQ1]
						end
					end
				end
				default: begin
					if (start_any) begin
						state_d   = ETDT_RUN; // see [RQ9]
						count_d   = reload_q; // see [RQ4]
						run_rel_d = reload_q;
						run_cfg_d = cfg_q; // see [RQ7]
						restart   = 1'b1;
					end
				end
			endcase
			if (run_cfg_d.tick_divider > `ETDT_DIV_MAX) begin
				run_cfg_d.tick_divider = `ETDT_DIV_MAX;
			end
		end
		// A set arriving with a clear is kept
		irq_d = irq_set | (irq_q & ~irq_clr);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q   <= ETDT_IDLE;
			count_q   <= 8'h00;
			run_rel_q <= 8'h00;
			run_cfg_q <= 6'h00;
			irq_q     <= 1'b0;
		end else begin
			state_q   <= state_d;
			count_q   <= count_d;
			run_rel_q <= run_rel_d;
			run_cfg_q <= run_cfg_d;
			irq_q     <= irq_d;
		end
	end

	// ==========================================================
	// Slot period counter; runs on encoder ticks, not timer ticks
	always_comb begin
		slot_on_d  = slot_on_q;
		slot_cnt_d = slot_cnt_q;
		send_d     = send_q;
		if (ce) begin
			send_d = 1'b0;
			if (cmd_done && (period != 9'h000)) begin
				slot_on_d  = 1'b1; // see [RQ13]
				slot_cnt_d = period;
			end else if (slot_on_q && encoder_tick) begin
				if (slot_cnt_q <= 9'h001) begin
					send_d = fifo_has_data; // see [RQ13]
					if (period != 9'h000) begin
						slot_cnt_d = period; // see [RQ15] [RQ14]
					end else begin
						slot_on_d = 1'b0; // see [RQ14]
					end
				end else begin
					slot_cnt_d = slot_cnt_q - 9'h001;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_on_q  <= 1'b0;
			slot_cnt_q <= 9'h000;
			send_q     <= 1'b0;
		end else begin
			slot_on_q  <= slot_on_d;
			slot_cnt_q <= slot_cnt_d;
			send_q     <= send_d;
		end
	end

	// Outputs straight from flops; no path into tx or rx control
	assign prdata           = prdata_q;
	assign pready           = pready_q;
	assign pslverr          = pslverr_q;
	assign timeout_irq_flag = irq_q; // see [RQ12]
	assign count_active     = state_q[1];
	assign slot_send        = send_q;

	// ==========================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_tick_decrement: assert property ( // see [RQ1]
		ce && running && tick && !stop_any && !start_any
		&& count_q > 8'h01 |=> count_q == $past(count_q) - 8'h01)
		else $error("count did not step down on tick");
	a_start_loads: assert property ( // see [RQ4]
		ce && start_any && !(running && stop_any)
		|=> count_q == $past(reload_q) && count_active)
		else $error("start did not load reload value");
	a_stop_halts: assert property ( // see [RQ5]
		ce && running && stop_any |=> !count_active)
		else $error("stop event did not halt timer");
	a_auto_skip_zero: assert property ( // see [RQ6]
		ce && running && tick && !stop_any && !start_any
		&& count_q == 8'h01 && run_cfg_q.auto_reload_en
		|=> count_q == run_rel_q && count_active && irq_q)
		else $error("auto reload missed");
	a_reload_isolated: assert property ( // see [RQ7]
		ce && running && !start_any && !tick |=> $stable(count_q))
		else $error("count moved without tick or start");
	a_halt_no_flag: assert property ( // see [RQ8]
		ce && running && halt_q |=> !$rose(irq_q))
		else $error("halt raised the timeout flag");
	a_idle_frozen: assert property ( // see [RQ9]
		!count_active && !(ce && start_any) |=> $stable(count_q))
		else $error("count changed while idle");
	a_expire_flags: assert property ( // see [RQ11]
		ce && running && tick && !stop_any && !start_any
		&& count_q == 8'h01 && !run_cfg_q.auto_reload_en
		|=> irq_q && !count_active && count_q == 8'h00)
		else $error("expiry did not flag and stop");
	a_slot_send: assert property ( // see [RQ13]
		ce && slot_on_q && encoder_tick && !cmd_done
		&& slot_cnt_q <= 9'h001 && fifo_has_data |=> slot_send)
		else $error("slot end did not request send");
	a_pulse_clears: assert property ( // see [RQ20]
		ce && go_q |=> !go_q)
		else $error("go pulse did not clear");
	a_apb_ready: assert property (
		ce && setup |=> pready ##1 (!pready || !ce))
		else $error("ready not one cycle after setup");

	c_expire: cover property (running && $rose(irq_q) && !count_active);
	c_auto: cover property (running && $rose(irq_q) ##1 count_active);
	c_halt: cover property (running && halt_q ##1 !count_active);
	c_slot: cover property (slot_on_q ##1 slot_send);
endmodule
`default_nettype wire

// ==== test/etdt_link_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module etdt_link_model (
	input  wire logic       pclk,         // Bus clock
	input  wire logic       presetn,      // Async reset, low
	input  wire logic [3:0] fire,         // Event request from the bench
	output etdt_pkg::etdt_evt_t evt,      // Link event pulses
	output logic            encoder_tick  // Encoder rate pulse
);
	import etdt_pkg::*;
	logic [1:0] div_q;
	// ==========================================================
	// Link side
	// Encoder clock every fourth cycle keeps slot intervals short
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 2'h0;
			encoder_tick <= 1'b0;
			evt <= '0;
		end else begin
			div_q <= div_q + 2'h1;
			encoder_tick <= (div_q == 2'h3);
			evt <= fire;  // Pulses last one cycle
		end
	end
endmodule
`default_nettype wire

// ==== test/etdt_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "etdt_defines.svh"
module etdt_top_tb_top;
	import etdt_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, cmd_done, err;
	logic        fifo_has_data, pready, pslverr, encoder_tick;
	logic        timeout_irq_flag, count_active, slot_send;
	logic [7:0]  paddr, lfsr, rl;
	logic [3:0]  fire;
	logic [31:0] pwdata, prdata, rdv;
	logic [8:0]  exp_slot, cnt;
	etdt_evt_t   evt;
	int          num_errors, num_checks, cyc, waited, sends, skip, n0;
	// ==========================================================
	// Clock, design and link model
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	etdt_top dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
		.cmd_done(cmd_done), .fifo_has_data(fifo_has_data),
		.encoder_tick(encoder_tick), .timeout_irq_flag(timeout_irq_flag),
		.count_active(count_active), .slot_send(slot_send));
	etdt_link_model link (.pclk(pclk), .presetn(presetn), .fire(fire),
		.evt(evt), .encoder_tick(encoder_tick));
	// ==========================================================
	// Helpers
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// Expected pclk cycles for r ticks of the divided chip clock
	function automatic int tick_cycles(input int r, input int d);
		return (r << d) * int'(`ETDT_PCLK_KHZ) / int'(`ETDT_CHIP_KHZ);
	endfunction
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR at %0t: word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR at %0t: bit %b expected %b", $time, got, exp);
		end
	endtask
	// One APB transfer; holds the request until pready is seen high
	// A slave that never answers is caught by the hang guard
	task automatic apb(input logic wr, input logic [5:0] idx,
			input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		chk_word(rdv, exp);
	endtask
	// Bounded wait on the flag (sel 0) or the running status (sel 1)
	task automatic wait_out(input int sel, input logic want, input int lim);
		logic s;
		waited = 0;
		do begin
			@(posedge pclk);
			waited++;
			s = (sel == 0) ? timeout_irq_flag : count_active;
		end while (s !== want && waited < lim);
		chk_bit(s, want);
	endtask
	task automatic pulse(input logic [3:0] f);
		@(posedge pclk);
		fire <= f;
		@(posedge pclk);
		fire <= 4'h0;
	endtask
	task automatic give_verdict();
		$display("Checks %0d, errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// ==========================================================
	// Slot monitor: encoder ticks between two send requests
	always @(posedge pclk) begin
		if (slot_send === 1'b1) begin
			if (sends > 0 && skip == 0) chk_word(cnt, exp_slot);
			if (skip > 0) skip--;
			sends++;
			cnt = 9'h0;
		end else begin
			cnt = cnt + encoder_tick;
		end
	end
	// Hang guard: a run far longer than planned counts as a failure
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			num_errors++;
			give_verdict();
		end
	end
	// ==========================================================
	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, cmd_done, fifo_has_data} = 6'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		fire = 4'h0;
		lfsr = 8'h15;
		cnt = 9'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(`ETDT_IDX_COUNT_NOW, 32'h0);
		rd_chk(`ETDT_IDX_AUX_STATUS, 32'h0);
		rd_chk(`ETDT_IDX_RELOAD, 32'h0);
		rd_chk(`ETDT_IDX_TICK_DIV, 32'h0);
		rd_chk(`ETDT_IDX_FLAGS, 32'h0);
		apb(1'b1, `ETDT_IDX_COUNT_NOW, 32'h55);
		rd_chk(`ETDT_IDX_COUNT_NOW, 32'h0);
		apb(1'b0, 6'h3F, 32'h0);
		chk_bit(err, 1'b1);
		// One-shot runs with random reload and divider
		// Flag is seen 3 cycles after the start edge plus the tick time,
		// and the bench starts counting 7 cycles after that edge
		repeat (3) begin
			lfsr = lfsr_next(lfsr);
			rl = 8'h2 + {5'h0, lfsr[2:0]};
			apb(1'b1, `ETDT_IDX_TICK_DIV, {27'h0, 3'h0, lfsr[4:3]});
			apb(1'b1, `ETDT_IDX_RELOAD, {24'h0, rl});
			apb(1'b1, `ETDT_IDX_CMD_CTRL, 32'h2);
			wait_out(1, 1'b1, 10);
			rd_chk(`ETDT_IDX_COUNT_NOW, {24'h0, rl});
			rd_chk(`ETDT_IDX_AUX_STATUS, 32'h80);
			wait_out(0, 1'b1, 1200);
			n0 = tick_cycles(rl, lfsr[4:3]);
			chk_bit(waited + 7 >= n0, 1'b1);
			chk_bit(waited + 4 <= n0 + 3, 1'b1);
			chk_bit(count_active, 1'b0);
			rd_chk(`ETDT_IDX_COUNT_NOW, 32'h0);
			apb(1'b1, `ETDT_IDX_FLAGS, 32'h1);
			rd_chk(`ETDT_IDX_FLAGS, 32'h0);
		end
		// Reload written mid-run, then retrigger, then software halt
		apb(1'b1, `ETDT_IDX_TICK_DIV, 32'h0);
		apb(1'b1, `ETDT_IDX_RELOAD, 32'hC8);
		apb(1'b1, `ETDT_IDX_CMD_CTRL, 32'h2);
		apb(1'b1, `ETDT_IDX_RELOAD, 32'h5);
		apb(1'b0, `ETDT_IDX_COUNT_NOW, 32'h0);
		chk_bit(rdv > 32'h5, 1'b1);
		apb(1'b1, `ETDT_IDX_CMD_CTRL, 32'h2);
		rd_chk(`ETDT_IDX_COUNT_NOW, 32'h5);
		apb(1'b1, `ETDT_IDX_CMD_CTRL, 32'h4);
		wait_out(1, 1'b0, 10);
		rd_chk(`ETDT_IDX_CMD_CTRL, 32'h0);
		repeat (100) @(posedge pclk);
		chk_bit(timeout_irq_flag, 1'b0);
		// Link events: start on tx, ignore a disabled stop, stop on rx
		apb(1'b1, `ETDT_IDX_RELOAD, 32'hC8);
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, `ETDT_IDX_TRIG_EN, 32'h5 << i);
			pulse(4'h8 >> i);
			wait_out(1, 1'b1, 10);
			pulse(4'h1 << i);
			repeat (3) @(posedge pclk);
			chk_bit(count_active, 1'b1);
			pulse(4'h2 >> i);
			wait_out(1, 1'b0, 10);
			chk_bit(timeout_irq_flag, 1'b0);
		end
		// Periodic trigger with auto reload
		apb(1'b1, `ETDT_IDX_TICK_DIV, 32'h20);
		apb(1'b1, `ETDT_IDX_RELOAD, 32'h3);
		apb(1'b1, `ETDT_IDX_CMD_CTRL, 32'h2);
		wait_out(0, 1'b1, 200);
		chk_bit(count_active, 1'b1);
		apb(1'b0, `ETDT_IDX_COUNT_NOW, 32'h0);
		chk_bit(rdv != 32'h0, 1'b1);
		apb(1'b1, `ETDT_IDX_FLAGS, 32'h1);
		wait_out(0, 1'b1, 200);
		apb(1'b1, `ETDT_IDX_CMD_CTRL, 32'h4);
		apb(1'b1, `ETDT_IDX_FLAGS, 32'h1);
		// Slot counter: random period, then a nine-bit one
		lfsr = lfsr_next(lfsr);
		exp_slot = 9'h3 + {5'h0, lfsr[3:0]};
		// Host queues a quit frame with check append off
		fifo_has_data <= 1'b1;
		apb(1'b1, `ETDT_IDX_SLOT_LO, {23'h0, exp_slot});
		@(posedge pclk);
		cmd_done <= 1'b1;
		@(posedge pclk);
		cmd_done <= 1'b0;
		n0 = 0;
		while (sends < 3 && n0 < 400) begin
			@(posedge pclk);
			n0++;
		end
		chk_bit(sends >= 3, 1'b1);
		skip = 1;
		exp_slot = 9'h102;
		apb(1'b1, `ETDT_IDX_AUX_SEL, 32'h1);
		apb(1'b1, `ETDT_IDX_SLOT_LO, 32'h2);
		n0 = sends + 2;
		repeat (2200) @(posedge pclk);
		chk_bit(sends >= n0, 1'b1);
		// Empty queue sends nothing; zero period stops the slots
		fifo_has_data <= 1'b0;
		n0 = sends;
		apb(1'b1, `ETDT_IDX_SLOT_LO, 32'h0);
		apb(1'b1, `ETDT_IDX_AUX_SEL, 32'h0);
		repeat (2200) @(posedge pclk);
		fifo_has_data <= 1'b1;
		repeat (1100) @(posedge pclk);
		chk_word(sends, n0);
		give_verdict();
	end
endmodule
`default_nettype wire
